//--- gfx_operand_map.svh
// Offsets, reset values and encodings of the colour and line operand bank.
// Included by the bank and the top; definitions only.
`ifndef GFX_OPERAND_MAP_SVH
`define GFX_OPERAND_MAP_SVH

// Register indexes on the software port (file B slots eight to fourteen)
`define IDX_BACKGROUND_COLOR 3'h0
`define IDX_FOREGROUND_COLOR 3'h1
`define IDX_LINE_PIXEL_COUNT 3'h2
`define IDX_DIAGONAL_STEP 3'h3
`define IDX_STRAIGHT_STEP 3'h4
`define IDX_LINE_PATTERN 3'h5
`define IDX_LINE_SCRATCH 3'h6
`define IDX_LAST 3'h6

// Number of words held
`define OPERAND_WORDS 7

// Reset value of every operand word
`define OPERAND_RESET 32'h00000000

// Background colour bits used during colour expansion
`define BG_USED_BITS 16

// Packed XY halves
`define XY_HALF 16

`endif

//--- gfx_operand_pkg.sv
// Types shared by the operand bank and its top.
// Assumes nothing beyond the map header.
package gfx_operand_pkg;

  // Drawing operation requested by the execution unit
  typedef enum logic [2:0] {
    OP_NONE,
    OP_FILL,
    OP_DRAW_ADVANCE,
    OP_LINE,
    OP_EXPAND
  } gfx_op_t;

  // Line stepper states
  typedef enum logic {
    L_IDLE,
    L_RUN
  } line_state_t;

  // Pixel size as log2 of bits per pixel: 0..4 for 1..16 bits
  typedef logic [2:0] pix_log_t;

endpackage

//--- operand_bank_if.sv
// Carrier between the top and the operand bank: one write port and word taps.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`include "gfx_operand_map.svh"

interface operand_bank_if;
  logic we;
  logic [2:0] widx;
  logic [31:0] wdata;
  logic [31:0] words [`OPERAND_WORDS];

  modport bank (input we, input widx, input wdata, output words);
  modport user (output we, output widx, output wdata, input words);
endinterface

//--- operand_bank.sv
// Seven 32-bit operand words with one write port; every word is a flop.
// Assumes the writer resolves contention before the port.
`timescale 1ns/1ns
`include "gfx_operand_map.svh"

module operand_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bank port
  operand_bank_if.bank bus
);

  genvar g;

  // One flop word per slot, holds until written
  generate
    for (g = 0; g < `OPERAND_WORDS; g++) begin : g_word
      logic [31:0] word_reg;
      logic hit;
      assign hit = bus.we && (bus.widx == 3'(g));
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          word_reg <= `OPERAND_RESET;
        end else if (hit) begin
          word_reg <= bus.wdata;
        end
      end
      assign bus.words[g] = word_reg;
    end
  endgenerate

endmodule

//--- graphics_color_line_operand_regs.sv
// Colour and line implied-operand registers with colour expansion and a line stepper.
// Assumes software port and execution unit run on clk_i; no synchronisers needed.
// Word map
// Index 0 background colour, index 1 foreground colour.
// Index 2 line pixel count, index 3 diagonal step, index 4 straight step.
// Index 5 line pattern, index 6 line scratch; index 7 is unmapped.
// Every word resets to zero, the pattern word included.
//
// Software port
// One-cycle write strobe with address and data; word updated at that edge.
// One-cycle read strobe with address; data stand in the next cycle only.
// Read data are zero in every other cycle, and for index 7.
// Strobes may follow each other with no gap, in any mix.
//
// Write priority
// Line scratch first, then execution unit temporaries, then software.
// A software write that meets a higher write in the same cycle is lost.
// Temporary writes to the two colour words are refused outright.
// Hazard: software must not load operands while a line or fill runs.
//
// Pixel word port
// Request with an operation; valid pulses one cycle later.
// Data stay on the port until the next request.
// An empty operation gives no valid and clears the data to zero.
// Expansion picks foreground or background per pixel slot of the word.
// Pixel size 5 to 7 maps every bit to slot 0; callers keep to 0 to 4.
//
// Line port
// Start is taken in idle only; the count word is copied at that edge.
// A zero count ends at once with a done pulse and no pixels.
// Each pixel handshake steps the position and decrements the copy.
// The new position is written to the scratch word on every step.
// Done pulses one cycle after the last handshake; busy drops with it.
// Diagonal or straight step is chosen by the level at the handshake.
// X and Y halves add apart; a carry out of X never reaches Y.
// The count word itself is never decremented, so a line can repeat.
//
// Limitations
// Pixel colour for a line is the whole foreground word; the consumer
// picks its slot. The pattern word is stored but not used by the line.
// Only the low half of the background word reaches expansion; it is
// repeated over both halves so slot alignment holds for every size.
//
// Timing
// Every output of the module comes from a flop, here or in the bank.
// No path crosses clocks; all inputs share clk_i.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "gfx_operand_map.svh"

module graphics_color_line_operand_regs
  import gfx_operand_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Software register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Temporary writes from block transfer and fill
  input wire logic tmp_we_i,
  input wire logic [2:0] tmp_idx_i,
  input wire logic [DATA_W-1:0] tmp_wdata_i,
  // Pixel word request
  input wire logic word_req_i,
  input wire gfx_op_t word_op_i,
  input wire pix_log_t pix_log_i,
  input wire logic [DATA_W-1:0] src_bits_i,
  output logic word_valid_o,
  output logic [DATA_W-1:0] word_data_o,
  // Line control
  input wire logic line_start_i,
  input wire logic [DATA_W-1:0] line_xy_i,
  input wire logic diag_step_i,
  input wire logic pix_ready_i,
  output logic pix_valid_o,
  output logic [DATA_W-1:0] pix_xy_o,
  output logic [DATA_W-1:0] pix_color_o,
  output logic line_busy_o,
  output logic line_done_o
);

  operand_bank_if bank_if ();

  operand_bank u_bank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bus(bank_if.bank)
  );

  // Operand taps
  wire logic [31:0] background_color = bank_if.words[`IDX_BACKGROUND_COLOR];
  wire logic [31:0] foreground_color = bank_if.words[`IDX_FOREGROUND_COLOR];
  wire logic [31:0] line_pixel_count = bank_if.words[`IDX_LINE_PIXEL_COUNT];
  wire logic [31:0] diagonal_step_increment = bank_if.words[`IDX_DIAGONAL_STEP];
  wire logic [31:0] straight_step_increment = bank_if.words[`IDX_STRAIGHT_STEP];

  // Line stepper state
  line_state_t lstate_reg;
  line_state_t lstate_next;
  logic [31:0] lcnt_reg;
  logic [31:0] lcnt_next;
  logic [31:0] pos_reg;
  logic [31:0] pos_next;
  logic pix_valid_reg;
  logic pix_valid_next;
  logic done_reg;
  logic done_next;
  logic busy_reg;
  logic busy_next;
  logic scratch_we;
  logic [31:0] step_xy;
  logic [31:0] stepped_xy;
  logic emit_take;

  // Read path registers
  logic [31:0] rdata_reg;
  logic word_valid_reg;
  logic [31:0] word_data_reg;

  // Write port selection: line scratch, then temporaries, then software
  wire logic tmp_ok = tmp_we_i && (tmp_idx_i >= `IDX_LINE_PIXEL_COUNT)
    && (tmp_idx_i <= `IDX_LAST);
  wire logic sw_ok = reg_we_i && (reg_addr_i <= `IDX_LAST);
  assign bank_if.we = scratch_we || tmp_ok || sw_ok;
  assign bank_if.widx = scratch_we ? `IDX_LINE_SCRATCH :
    (tmp_ok ? tmp_idx_i : reg_addr_i);
  assign bank_if.wdata = scratch_we ? stepped_xy :
    (tmp_ok ? tmp_wdata_i : reg_wdata_i);

  // Software read decode, unmapped reads zero
  logic [31:0] rd_masked [`OPERAND_WORDS];
  logic [31:0] rd_sel;
  genvar r;
  generate
    for (r = 0; r < `OPERAND_WORDS; r++) begin : g_rd
      wire logic rd_hit = (reg_addr_i == 3'(r));
      assign rd_masked[r] = rd_hit ? bank_if.words[r] : 32'h00000000;
    end
  endgenerate

  // OR of the masked words; index 7 hits none and reads zero
  always_comb begin
    rd_sel = 32'h00000000;
    for (int i = 0; i < `OPERAND_WORDS; i++) begin
      rd_sel = rd_sel | rd_masked[i];
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= reg_re_i ? rd_sel : 32'h00000000;
    end
  end

  // Background uses only its low half, repeated so alignment still holds
  wire logic [31:0] bg_eff = {2{background_color[`BG_USED_BITS-1:0]}};

  // Colour expansion: each bit picks fg or bg by the source bit of its pixel slot
  logic [31:0] expanded;
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_exp
      wire logic [4:0] slot = 5'(b) >> pix_log_i;
      assign expanded[b] = src_bits_i[slot] ? foreground_color[b] : bg_eff[b];
    end
  endgenerate

  // Word selected for the requested operation
  wire logic [31:0] word_sel = (word_op_i == OP_EXPAND) ? expanded :
    ((word_op_i == OP_NONE) ? 32'h00000000 : foreground_color);

  // Pixel word register, one cycle after the request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_valid_reg <= 1'b0;
      word_data_reg <= 32'h00000000;
    end else begin
      word_valid_reg <= word_req_i && (word_op_i != OP_NONE);
      word_data_reg <= word_req_i ? word_sel : word_data_reg;
    end
  end

  // Step selection and packed XY add, halves do not carry into each other
  assign step_xy = diag_step_i ? diagonal_step_increment : straight_step_increment;

  // Packed XY add per half; X carry never reaches Y
  wire logic [15:0] step_x = pos_reg[15:0] + step_xy[15:0];
  wire logic [15:0] step_y = pos_reg[31:16] + step_xy[31:16];
  assign stepped_xy = {step_y, step_x};

  // Handshake of the offered pixel
  assign emit_take = pix_valid_reg && pix_ready_i;

  // Line stepper next state
  always_comb begin
    lstate_next = lstate_reg;
    lcnt_next = lcnt_reg;
    pos_next = pos_reg;
    pix_valid_next = pix_valid_reg;
    done_next = 1'b0;
    busy_next = busy_reg;
    scratch_we = 1'b0;
    case (lstate_reg)
      L_IDLE: begin
        if (line_start_i) begin
          pos_next = line_xy_i;
          lcnt_next = line_pixel_count;
          if (line_pixel_count == 32'h00000000) begin
            done_next = 1'b1; // Zero count draws nothing
          end else begin
            lstate_next = L_RUN;
            pix_valid_next = 1'b1;
            busy_next = 1'b1;
          end
        end
      end
      L_RUN: begin
        if (emit_take) begin
          scratch_we = 1'b1;
          pos_next = stepped_xy;
          lcnt_next = lcnt_reg - 32'h00000001;
          if (lcnt_reg == 32'h00000001) begin
            lstate_next = L_IDLE;
            pix_valid_next = 1'b0;
            busy_next = 1'b0;
            done_next = 1'b1;
          end
        end
      end
      default: begin
        lstate_next = L_IDLE;
        pix_valid_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  // Line stepper registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lstate_reg <= L_IDLE;
      lcnt_reg <= 32'h00000000;
      pos_reg <= 32'h00000000;
      pix_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      lstate_reg <= lstate_next;
      lcnt_reg <= lcnt_next;
      pos_reg <= pos_next;
      pix_valid_reg <= pix_valid_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  // Outputs straight from flops; line colour is the foreground word
  assign reg_rdata_o = rdata_reg;
  assign word_valid_o = word_valid_reg;
  assign word_data_o = word_data_reg;
  assign pix_valid_o = pix_valid_reg;
  assign pix_xy_o = pos_reg;
  assign pix_color_o = foreground_color;
  assign line_busy_o = busy_reg;
  assign line_done_o = done_reg;

endmodule

//--- gcl_props.sv
// Port checker for the colour and line operand registers.
// Bound to the top; sees only its ports, one clock domain.
`timescale 1ns/1ns
module gcl_props
  import gfx_operand_pkg::*;
#(parameter int DATA_W = 32) (
  // Clock, reset and software port
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Word and line ports
  input wire logic word_req_i,
  input wire gfx_op_t word_op_i,
  input wire logic word_valid_o,
  input wire logic [DATA_W-1:0] word_data_o,
  input wire logic line_start_i,
  input wire logic pix_ready_i,
  input wire logic pix_valid_o,
  input wire logic [DATA_W-1:0] pix_xy_o,
  input wire logic [DATA_W-1:0] pix_color_o,
  input wire logic line_busy_o,
  input wire logic line_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Word requests, register reads and line progress
  a_word_fg_value: assert property (word_req_i
    && word_op_i inside {OP_FILL, OP_DRAW_ADVANCE, OP_LINE}
    && !(reg_we_i && reg_addr_i == 3'h1) |=> word_valid_o && word_data_o == pix_color_o)
    else $error("fill word differs from foreground");
  a_none_no_valid: assert property (word_req_i && word_op_i == OP_NONE |=> !word_valid_o)
    else $error("valid after empty request");
  a_fg_kept: assert property (!(reg_we_i && reg_addr_i == 3'h1) |=> $stable(pix_color_o))
    else $error("foreground changed without a write");
  a_rdata_idle: assert property (!reg_re_i || reg_addr_i == 3'h7 |=> reg_rdata_o == '0)
    else $error("read data not zero");
  a_pix_held: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_xy_o))
    else $error("pixel dropped before handshake");
  a_line_end: assert property ($fell(line_busy_o) |-> line_done_o)
    else $error("line ended without done");
  a_start_resp: assert property (line_start_i && !line_busy_o |=> line_busy_o || line_done_o)
    else $error("line start not taken");
  a_done_pulse: assert property (line_done_o |=> !line_done_o ##1 !line_done_o)
    else $error("done longer than one cycle");
  a_valid_busy: assert property (pix_valid_o |-> line_busy_o && !line_done_o)
    else $error("pixel offered while idle");

  c_expand: cover property (word_req_i && word_op_i == OP_EXPAND ##1 word_valid_o);
  c_stall: cover property (pix_valid_o && !pix_ready_i);
  c_done: cover property (line_done_o);
endmodule

bind graphics_color_line_operand_regs gcl_props #(.DATA_W(DATA_W)) i_gcl_props (.clk_i, .rst_n_i,
  .reg_addr_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .word_req_i, .word_op_i, .word_valid_o,
  .word_data_o, .line_start_i, .pix_ready_i, .pix_valid_o, .pix_xy_o, .pix_color_o, .line_busy_o,
  .line_done_o);

//--- pix_sink_model.sv
// Pixel consumer on the execution unit side.
// Assumes the block's clock and reset.
`timescale 1ns/1ns
module pix_sink_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic pix_ready_o
);
  logic [1:0] cnt_reg;
  // Free counter; consumer stalls one cycle in four
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  assign pix_ready_o = (cnt_reg != 2'h3);
endmodule

//--- graphics_color_line_operand_regs_tb.sv
// Testbench for the colour and line operand registers.
// Drives software, temp, word and line ports; a sink model takes pixels.
`timescale 1ns/1ns
module graphics_color_line_operand_regs_tb import gfx_operand_pkg::*;;
  localparam logic [31:0] FG = 32'hFEDCBA98;
  localparam logic [31:0] BG = 32'hA5A51234;
  localparam logic [31:0] P0 = 32'h00100020;
  localparam logic [31:0] DI = 32'h00010001;
  localparam logic [31:0] ST = 32'h00000001;
  logic clk_i, rst_n_i, reg_we_i, reg_re_i, tmp_we_i, word_req_i, word_valid_o;
  logic line_start_i, diag_step_i, pix_ready_i, pix_valid_o, line_busy_o, line_done_o;
  logic [2:0] reg_addr_i, tmp_idx_i;
  pix_log_t pix_log_i;
  gfx_op_t word_op_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, tmp_wdata_i, src_bits_i, word_data_o;
  logic [31:0] line_xy_i, pix_xy_o, pix_color_o;
  int mismatches, compares;

  graphics_color_line_operand_regs i_graphics_color_line_operand_regs (.clk_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .tmp_we_i, .tmp_idx_i,
    .tmp_wdata_i, .word_req_i, .word_op_i, .pix_log_i, .src_bits_i, .word_valid_o,
    .word_data_o, .line_start_i, .line_xy_i, .diag_step_i, .pix_ready_i, .pix_valid_o,
    .pix_xy_o, .pix_color_o, .line_busy_o, .line_done_o);
  pix_sink_model i_pix_sink_model (.clk_i, .rst_n_i, .pix_ready_o(pix_ready_i));

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus and request tasks; entered and left on a rising edge
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(posedge clk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic tmpw(input logic [2:0] a, input logic [31:0] d);
    tmp_idx_i <= a;
    tmp_wdata_i <= d;
    tmp_we_i <= 1'b1;
    @(posedge clk_i);
    tmp_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wreq(input gfx_op_t op, input pix_log_t pl, input logic [31:0] s,
                      input logic [31:0] e);
    word_req_i <= 1'b1;
    word_op_i <= op;
    pix_log_i <= pl;
    src_bits_i <= s;
    @(posedge clk_i);
    word_req_i <= 1'b0;
    @(posedge clk_i);
    chkb(word_valid_o, op != OP_NONE);
    if (op != OP_NONE) chk(word_data_o, e);
  endtask
  function automatic logic [31:0] expand(input logic [31:0] s, input int pl);
    for (int b = 0; b < 32; b++) expand[b] = s[b >> pl] ? FG[b] : BG[b % 16];
  endfunction
  function automatic logic [31:0] step(input logic [31:0] p, input logic [31:0] d);
    step = {p[31:16] + d[31:16], p[15:0] + d[15:0]};
  endfunction

  // Draws one line, following each handshake with its own expectation
  task automatic run_line(input logic [31:0] cnt);
    logic [31:0] xy;
    int n;
    int d;
    wr(3'h2, cnt);
    line_start_i <= 1'b1;
    line_xy_i <= P0;
    @(posedge clk_i);
    line_start_i <= 1'b0;
    xy = P0;
    n = 0;
    d = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
        chk(pix_xy_o, xy);
        chk(pix_color_o, FG);
        xy = step(xy, diag_step_i ? DI : ST);
        n++;
        diag_step_i <= ~diag_step_i;
      end
      if (line_done_o === 1'b1) d++;
    end
    chk(32'(n), cnt);
    chk(32'(d), 32'h1);
    chkb(line_busy_o, 1'b0);
    if (cnt != 0) rd(3'h6, xy);
    rd(3'h2, cnt);
  endtask

  // Watchdog
  initial begin
    #10000;
    mismatches++;
    final_report();
  end

  // Main sequence
  initial begin
    {reg_we_i, reg_re_i, tmp_we_i, word_req_i, line_start_i, diag_step_i} = 6'h00;
    {reg_addr_i, tmp_idx_i, pix_log_i} = 9'h000;
    {reg_wdata_i, tmp_wdata_i, src_bits_i, line_xy_i} = 128'h0;
    word_op_i = OP_NONE;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) rd(3'(i), 32'h0);
    for (int i = 0; i < 8; i++) wr(3'(i), 32'h11111111 * 32'(i + 1));
    for (int i = 0; i < 8; i++) rd(3'(i), i < 7 ? 32'h11111111 * 32'(i + 1) : 32'h0);
    wr(3'h0, BG);
    wr(3'h1, FG);
    wr(3'h3, DI);
    wr(3'h4, ST);
    tmpw(3'h0, 32'h0);
    tmpw(3'h1, 32'h0);
    tmpw(3'h5, 32'h12345678);
    rd(3'h1, FG);
    rd(3'h0, BG);
    rd(3'h5, 32'h12345678);
    wr(3'h5, 32'h0FFFFFFF);
    wreq(OP_NONE, 3'h0, 32'h0, 32'h0);
    wreq(OP_FILL, 3'h2, 32'h0, FG);
    wreq(OP_DRAW_ADVANCE, 3'h2, 32'h0, FG);
    wreq(OP_LINE, 3'h2, 32'h0, FG);
    for (int k = 0; k < 5; k++) begin
      wreq(OP_EXPAND, 3'(k), 32'h0000C35A, expand(32'h0000C35A, k));
    end
    run_line(32'h3);
    run_line(32'h0);
    rd(3'h1, FG);
    rd(3'h0, BG);
    wr(3'h1, 32'h33333333);
    rd(3'h1, 32'h33333333);
    final_report();
  end
endmodule
